// ===== pteu_pkg.sv
// ----------------------------------------------------------------------------
// shared types and constants of the entry update sequencer
// ----------------------------------------------------------------------------
package pteu_pkg;

  localparam int unsigned ADDR_W = 64;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned STEP_W = 4;

  // ---------------------------------------------------------------------------
  // entry layout: high doubleword at offset 0, low doubleword at offset 8
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] HIGH_DW_OFFSET   = 64'h0000_0000_0000_0000;
  localparam logic [ADDR_W-1:0] LOW_DW_OFFSET    = 64'h0000_0000_0000_0008;
  // byte holding referenced_flag, bits 8-15 of the low doubleword
  localparam logic [ADDR_W-1:0] RBYTE_OFFSET     = 64'h0000_0000_0000_000E;
  localparam int unsigned       VALID_BIT        = 0;
  localparam int unsigned       REF_BIT_IN_BYTE  = 0;
  localparam logic [7:0]        RBYTE_CLEAR_MASK = 8'hFE;
  // address_compare_bit, no_execute_bit and page_protection_bits
  localparam logic [DATA_W-1:0] PROT_MASK        = 64'h0000_0000_0000_0207;
  // referenced_flag and changed_flag, owned by the translation hardware
  localparam logic [DATA_W-1:0] REF_CHG_MASK     = 64'h0000_0000_0000_0180;
  localparam int unsigned       COND_OK_BIT      = 0;

  // ---------------------------------------------------------------------------
  // sequence landmarks
  // ---------------------------------------------------------------------------
  localparam logic [STEP_W-1:0] CLRREF_UNLOCK_STEP = 4'h7;
  localparam logic [STEP_W-1:0] CAS_LOAD_STEP      = 4'h2;

  typedef enum logic [2:0] {
    CMD_ADD,
    CMD_MODIFY,
    CMD_CLEAR_REF,
    CMD_MODIFY_VA,
    CMD_MODIFY_PROT,
    CMD_DELETE
  } pteu_cmd_e;

  typedef enum logic [3:0] {
    OPC_LOCK,
    OPC_UNLOCK,
    OPC_STORE_LOW,
    OPC_STORE_HIGH,
    OPC_CLEAR_VALID,
    OPC_READ_RBYTE,
    OPC_STORE_RBYTE,
    OPC_BARRIER,
    OPC_ENTRY_SYNC,
    OPC_INVALIDATE,
    OPC_INV_SYNC,
    OPC_RESV_LOAD,
    OPC_COND_STORE
  } pteu_opc_e;

  typedef struct packed {
    pteu_cmd_e         kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] low;
    logic [DATA_W-1:0] high;
    logic [ADDR_W-1:0] old_vpn;
  } pteu_cmd_s;

  typedef struct packed {
    pteu_opc_e         code;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pteu_op_s;

  typedef struct packed {
    pteu_opc_e code;
    logic      mp_only;
    logic      last;
  } pteu_step_s;

endpackage

// ===== pteu_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pteu_pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } pteu_sync_s;

  pteu_sync_s q;
  pteu_sync_s d;

  if (W < 1) begin : g_bad_width
    $error("pteu_pin_sync: W must be at least 1");
  end

  // a bit is taken only once the second and third stages agree
  always_comb begin
    d    = q;
    d.s1 = d_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < int'(W); i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.o;

endmodule
`default_nettype wire

// ===== pteu_op_port.sv
`timescale 1ns/10ps
`default_nettype none
module pteu_op_port (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            start_i,
  input  var  pteu_pkg::pteu_op_s              op_i,
  input  wire logic                            ack_i,
  input  wire logic [pteu_pkg::DATA_W-1:0]     rdata_i,
  output logic                                 req_o,
  output pteu_pkg::pteu_op_s                   op_o,
  output logic                                 done_o,
  output logic      [pteu_pkg::DATA_W-1:0]     rdata_o
);

  typedef enum logic [1:0] {
    P_IDLE,
    P_WAIT_HIGH,
    P_WAIT_LOW
  } pteu_port_st_e;

  typedef struct packed {
    pteu_port_st_e                st;
    logic                         req;
    pteu_pkg::pteu_op_s           op;
    logic                         done;
    logic [pteu_pkg::DATA_W-1:0]  rdata;
  } pteu_port_s;

  pteu_port_s q;
  pteu_port_s d;

  // ---------------------------------------------------------------------------
  // four-phase handshake; op and data stay put while req is high
  // ---------------------------------------------------------------------------
  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.st)
      P_IDLE: begin
        if (start_i) begin
          d.op  = op_i;
          d.req = 1'b1;
          d.st  = P_WAIT_HIGH;
        end
      end
      P_WAIT_HIGH: begin
        if (ack_i) begin
          d.rdata = rdata_i;
          d.req   = 1'b0;
          d.st    = P_WAIT_LOW;
        end
      end
      P_WAIT_LOW: begin
        if (!ack_i) begin
          d.done = 1'b1;
          d.st   = P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: P_IDLE, op: '{code: pteu_pkg::OPC_LOCK, addr: '0, data: '0}, default: '0};
    end else begin
      q <= d;
    end
  end

  assign req_o   = q.req;
  assign op_o    = q.op;
  assign done_o  = q.done;
  assign rdata_o = q.rdata;

endmodule
`default_nettype wire

// ===== pteu_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module pteu_sequencer (
  input  wire logic                            CORE_CLK_I,
  input  wire logic                            SYS_RST_I,
  input  wire logic                            CMD_VALID_I,
  input  var  pteu_pkg::pteu_cmd_s             CMD_I,
  input  wire logic                            MP_SYSTEM_I,
  output logic                                 CMD_READY_O,
  output logic                                 CMD_DONE_O,
  output logic                                 CMD_REF_WAS_SET_O,
  output logic                                 OP_REQ_O,
  output pteu_pkg::pteu_op_s                   OP_O,
  input  wire logic                            OP_ACK_I,
  input  wire logic [pteu_pkg::DATA_W-1:0]     OP_RDATA_I
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } pteu_main_st_e;

  typedef struct packed {
    pteu_main_st_e                   st;
    pteu_pkg::pteu_cmd_s             cmd;
    logic                            mp;
    logic [pteu_pkg::STEP_W-1:0]     step;
    logic [7:0]                      rbyte;
    logic [pteu_pkg::DATA_W-1:0]     resv;
    logic                            ready;
    logic                            done;
    logic                            ref_set;
  } pteu_main_s;

  pteu_main_s                      q;
  pteu_main_s                      d;
  pteu_pkg::pteu_step_s            e;
  pteu_pkg::pteu_op_s              op_new;
  logic                            op_start;
  logic                            op_done;
  logic [pteu_pkg::DATA_W-1:0]     op_rdata;
  logic [pteu_pkg::DATA_W:0]       pin_sync;
  logic                            op_req;
  pteu_pkg::pteu_op_s              op_cur;

  // ---------------------------------------------------------------------------
  // sequence tables
  // ---------------------------------------------------------------------------
  function automatic pteu_pkg::pteu_step_s mk(input pteu_pkg::pteu_opc_e c, input logic mp, input logic l);
    pteu_pkg::pteu_step_s s;
    s.code    = c;
    s.mp_only = mp;
    s.last    = l;
    return s;
  endfunction

  // shared tail: invalidate, barrier, inv-sync, entry sync
  function automatic pteu_pkg::pteu_step_s inv_tail(input logic [1:0] i);
    pteu_pkg::pteu_step_s s;
    s = mk(pteu_pkg::OPC_INVALIDATE, 1'b0, 1'b0);
    unique case (i)
      2'h0: s = mk(pteu_pkg::OPC_INVALIDATE, 1'b0, 1'b0);
      2'h1: s = mk(pteu_pkg::OPC_BARRIER, 1'b1, 1'b0);
      2'h2: s = mk(pteu_pkg::OPC_INV_SYNC, 1'b1, 1'b0);
      2'h3: s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
    endcase
    return s;
  endfunction

  function automatic pteu_pkg::pteu_step_s seq_step(input pteu_pkg::pteu_cmd_e k, input logic [3:0] n);
    pteu_pkg::pteu_step_s s;
    // lock and unlock are wrapped around every kind of update
    s = mk(pteu_pkg::OPC_UNLOCK, 1'b1, 1'b1);
    if (n == 4'h0) begin
      s = mk(pteu_pkg::OPC_LOCK, 1'b1, 1'b0);
    end else begin
      unique case (k)
        pteu_pkg::CMD_ADD: begin
          unique case (n)
            4'h1:    s = mk(pteu_pkg::OPC_STORE_LOW, 1'b0, 1'b0);
            4'h2:    s = mk(pteu_pkg::OPC_BARRIER, 1'b0, 1'b0);
            4'h3:    s = mk(pteu_pkg::OPC_STORE_HIGH, 1'b0, 1'b0);
            4'h4:    s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
            default: s = mk(pteu_pkg::OPC_UNLOCK, 1'b1, 1'b1);
          endcase
        end
        pteu_pkg::CMD_MODIFY: begin
          unique case (n)
            4'h1:    s = mk(pteu_pkg::OPC_CLEAR_VALID, 1'b0, 1'b0);
            4'h2:    s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
            4'h3, 4'h4, 4'h5, 4'h6: s = inv_tail(2'(n - 4'h3));
            4'h7:    s = mk(pteu_pkg::OPC_STORE_LOW, 1'b0, 1'b0);
            4'h8:    s = mk(pteu_pkg::OPC_BARRIER, 1'b0, 1'b0);
            4'h9:    s = mk(pteu_pkg::OPC_STORE_HIGH, 1'b0, 1'b0);
            4'hA:    s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
            default: s = mk(pteu_pkg::OPC_UNLOCK, 1'b1, 1'b1);
          endcase
        end
        pteu_pkg::CMD_CLEAR_REF: begin
          unique case (n)
            4'h1:    s = mk(pteu_pkg::OPC_READ_RBYTE, 1'b0, 1'b0);
            4'h2:    s = mk(pteu_pkg::OPC_STORE_RBYTE, 1'b0, 1'b0);
            4'h3, 4'h4, 4'h5, 4'h6: s = inv_tail(2'(n - 4'h3));
            default: s = mk(pteu_pkg::OPC_UNLOCK, 1'b1, 1'b1);
          endcase
        end
        pteu_pkg::CMD_MODIFY_VA: begin
          unique case (n)
            4'h1:    s = mk(pteu_pkg::OPC_STORE_HIGH, 1'b0, 1'b0);
            4'h2:    s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
            4'h3, 4'h4, 4'h5, 4'h6: s = inv_tail(2'(n - 4'h3));
            default: s = mk(pteu_pkg::OPC_UNLOCK, 1'b1, 1'b1);
          endcase
        end
        pteu_pkg::CMD_MODIFY_PROT: begin
          unique case (n)
            4'h1:    s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
            4'h2:    s = mk(pteu_pkg::OPC_RESV_LOAD, 1'b0, 1'b0);
            4'h3:    s = mk(pteu_pkg::OPC_COND_STORE, 1'b0, 1'b0);
            4'h4:    s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
            4'h5, 4'h6, 4'h7, 4'h8: s = inv_tail(2'(n - 4'h5));
            default: s = mk(pteu_pkg::OPC_UNLOCK, 1'b1, 1'b1);
          endcase
        end
        default: begin
          unique case (n)
            4'h1:    s = mk(pteu_pkg::OPC_CLEAR_VALID, 1'b0, 1'b0);
            4'h2:    s = mk(pteu_pkg::OPC_ENTRY_SYNC, 1'b0, 1'b0);
            4'h3, 4'h4, 4'h5, 4'h6: s = inv_tail(2'(n - 4'h3));
            default: s = mk(pteu_pkg::OPC_UNLOCK, 1'b1, 1'b1);
          endcase
        end
      endcase
    end
    return s;
  endfunction

  // ---------------------------------------------------------------------------
  // operation builder: only entry words are ever written
  // ---------------------------------------------------------------------------
  always_comb begin
    e           = seq_step(q.cmd.kind, q.step);
    op_new.code = e.code;
    op_new.addr = q.cmd.addr;
    op_new.data = '0;
    unique case (e.code)
      pteu_pkg::OPC_STORE_LOW: begin
        op_new.addr = q.cmd.addr + pteu_pkg::LOW_DW_OFFSET;
        op_new.data = q.cmd.low;
      end
      pteu_pkg::OPC_STORE_HIGH: begin
        op_new.addr = q.cmd.addr + pteu_pkg::HIGH_DW_OFFSET;
        op_new.data = q.cmd.high;
        op_new.data[pteu_pkg::VALID_BIT] = 1'b1;
      end
      pteu_pkg::OPC_CLEAR_VALID: begin
        op_new.addr = q.cmd.addr + pteu_pkg::HIGH_DW_OFFSET;
      end
      pteu_pkg::OPC_READ_RBYTE, pteu_pkg::OPC_STORE_RBYTE: begin
        // a byte store leaves changed_flag, in the next byte, alone
        op_new.addr = q.cmd.addr + pteu_pkg::RBYTE_OFFSET;
        op_new.data = {56'h0, q.rbyte & pteu_pkg::RBYTE_CLEAR_MASK};
      end
      pteu_pkg::OPC_RESV_LOAD: begin
        op_new.addr = q.cmd.addr + pteu_pkg::LOW_DW_OFFSET;
      end
      pteu_pkg::OPC_COND_STORE: begin
        op_new.addr = q.cmd.addr + pteu_pkg::LOW_DW_OFFSET;
        op_new.data = (q.resv & ~pteu_pkg::PROT_MASK) | (q.cmd.low & pteu_pkg::PROT_MASK);
      end
      pteu_pkg::OPC_INVALIDATE: begin
        op_new.addr = q.cmd.old_vpn;
      end
      pteu_pkg::OPC_BARRIER, pteu_pkg::OPC_ENTRY_SYNC, pteu_pkg::OPC_INV_SYNC: begin
        op_new.addr = '0;
      end
      default: begin
        op_new.addr = q.cmd.addr;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // main sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    d        = q;
    d.done   = 1'b0;
    op_start = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (CMD_VALID_I) begin
          d.cmd     = CMD_I;
          d.mp      = MP_SYSTEM_I;
          d.step    = '0;
          d.ready   = 1'b0;
          d.ref_set = 1'b0;
          d.st      = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (e.mp_only && !q.mp) begin
          // single processor: step dropped, one idle cycle spent
          d.step = q.step + 4'h1;
          if (e.last) begin
            d.st    = ST_IDLE;
            d.ready = 1'b1;
            d.done  = 1'b1;
          end
        end else begin
          op_start = 1'b1;
          d.st     = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (op_done) begin
          d.st   = ST_ISSUE;
          d.step = q.step + 4'h1;
          unique case (e.code)
            pteu_pkg::OPC_READ_RBYTE: begin
              d.rbyte   = op_rdata[7:0];
              d.ref_set = op_rdata[pteu_pkg::REF_BIT_IN_BYTE];
              if (!op_rdata[pteu_pkg::REF_BIT_IN_BYTE]) begin
                d.step = pteu_pkg::CLRREF_UNLOCK_STEP;
              end
            end
            pteu_pkg::OPC_RESV_LOAD: begin
              d.resv = op_rdata;
            end
            pteu_pkg::OPC_COND_STORE: begin
              if (!op_rdata[pteu_pkg::COND_OK_BIT]) begin
                d.step = pteu_pkg::CAS_LOAD_STEP;
              end
            end
            default: begin
            end
          endcase
          if (e.last) begin
            d.st    = ST_IDLE;
            d.ready = 1'b1;
            d.done  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      q <= '{st: ST_IDLE, ready: 1'b1, cmd: '{kind: pteu_pkg::CMD_ADD, default: '0}, default: '0};
    end else begin
      q <= d;
    end
  end

  pteu_pin_sync #(
    .W (pteu_pkg::DATA_W + 1)
  ) u_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   ({OP_ACK_I, OP_RDATA_I}),
    .q_o   (pin_sync)
  );

  pteu_op_port u_port (
    .clk_i   (CORE_CLK_I),
    .rst_i   (SYS_RST_I),
    .start_i (op_start),
    .op_i    (op_new),
    .ack_i   (pin_sync[pteu_pkg::DATA_W]),
    .rdata_i (pin_sync[pteu_pkg::DATA_W-1:0]),
    .req_o   (op_req),
    .op_o    (op_cur),
    .done_o  (op_done),
    .rdata_o (op_rdata)
  );

  assign CMD_READY_O       = q.ready;
  assign CMD_DONE_O        = q.done;
  assign CMD_REF_WAS_SET_O = q.ref_set;
  assign OP_REQ_O          = op_req;
  assign OP_O              = op_cur;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  pteu_pkg::pteu_opc_e prev_code_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      prev_code_q <= pteu_pkg::OPC_LOCK;
    end else if ($rose(op_req)) begin
      prev_code_q <= op_cur.code;
    end
  end

  a_high_sets_valid: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_req) && op_cur.code == pteu_pkg::OPC_STORE_HIGH |-> op_cur.data[pteu_pkg::VALID_BIT])
    else $error("high store without valid set");

  a_high_after_barrier: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_req) && op_cur.code == pteu_pkg::OPC_STORE_HIGH && q.cmd.kind != pteu_pkg::CMD_MODIFY_VA
    |-> prev_code_q == pteu_pkg::OPC_BARRIER)
    else $error("high store not ordered behind barrier");

  a_invsync_then_sync: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_req) && prev_code_q == pteu_pkg::OPC_INV_SYNC |-> op_cur.code == pteu_pkg::OPC_ENTRY_SYNC)
    else $error("invalidate-sync not followed by entry sync");

  a_clear_valid_sync: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_req) && prev_code_q == pteu_pkg::OPC_CLEAR_VALID |-> op_cur.code == pteu_pkg::OPC_ENTRY_SYNC)
    else $error("valid clear not followed by entry sync");

  a_single_no_lock: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_req) && !q.mp |-> op_cur.code != pteu_pkg::OPC_LOCK && op_cur.code != pteu_pkg::OPC_INV_SYNC)
    else $error("lock or invalidate-sync issued on single processor");

  a_rbyte_masked: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_req) && op_cur.code == pteu_pkg::OPC_STORE_RBYTE
    |-> op_cur.data[7:0] == (q.rbyte & 8'hFE) && q.rbyte[0])
    else $error("referenced byte store wrong");

  a_cas_keeps_flags: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    $rose(op_req) && op_cur.code == pteu_pkg::OPC_COND_STORE
    |-> (op_cur.data & pteu_pkg::REF_CHG_MASK) == (q.resv & pteu_pkg::REF_CHG_MASK))
    else $error("conditional store overwrites flags");

  a_op_held: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    op_req && !$rose(op_req) |-> $stable(op_cur))
    else $error("operation changed while requested");

  a_invsync_waits: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    q.st == ST_WAIT && e.code == pteu_pkg::OPC_INV_SYNC && !op_done |=> q.st == ST_WAIT)
    else $error("invalidate-sync left before its acknowledge");

  a_done_ready: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
    q.done |-> q.ready && !op_req && $past(op_cur.code) == pteu_pkg::OPC_UNLOCK || !q.mp)
    else $error("command finished without unlock");

endmodule
`default_nettype wire

// ===== pteu_notes_end.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== pteu_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------------------
// table memory side: low entry word, lock, sync service
// ---------------------------------------------------------------------------
module pteu_dev_model (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               req_i,
  input  var  pteu_pkg::pteu_op_s op_i,
  input  wire logic               ref_i,
  input  wire logic               fail_i,
  input  wire logic [1:0]         dly_i,
  output logic                    ack_o,
  output logic [63:0]             rdata_o
);
  logic [63:0] mem_q;
  logic [63:0] v;
  logic        used_q;
  // only the low entry word lives here, plus the used_q miss flag
  initial begin
    ack_o = 1'b0;
    rdata_o = 64'h0;
    mem_q = 64'h0;
    used_q = 1'b0;
    forever begin
      @(posedge clk_i);
      if (rst_i) begin
        ack_o <= 1'b0;
        used_q = 1'b0;
      end else if (req_i && !ack_o) begin
        v = ~rdata_o;
        case (op_i.code)
          pteu_pkg::OPC_READ_RBYTE: v = {56'h0, 7'h29, ref_i};
          pteu_pkg::OPC_STORE_LOW: mem_q = op_i.data;
          // one forced miss per update sequence, rearmed by the sync in front of it
          pteu_pkg::OPC_ENTRY_SYNC: used_q = 1'b0;
          // reload sets flags unsynchronised, nothing else
          pteu_pkg::OPC_RESV_LOAD: v = mem_q | pteu_pkg::REF_CHG_MASK;
          pteu_pkg::OPC_COND_STORE: begin
            v = {63'h0, !(fail_i && !used_q)};
            used_q = 1'b1;
            if (v[0]) mem_q = op_i.data;
          end
          default: ;
        endcase
        rdata_o <= v;
        repeat (dly_i) @(posedge clk_i);
        // remote invalidates land late; stale until then
        if (op_i.code == pteu_pkg::OPC_INV_SYNC) repeat (3) @(posedge clk_i);
        @(posedge clk_i);
        ack_o <= 1'b1;
        do @(posedge clk_i); while (req_i);
        ack_o <= 1'b0;
      end else begin
        rdata_o <= ~rdata_o;
      end
    end
  end
endmodule
`default_nettype wire

// ===== pteu_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin err_count++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module pteu_sequencer_bench;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                vld = 1'b0;
  logic                mp = 1'b0;
  logic                ref_b = 1'b0;
  logic                fail = 1'b0;
  logic [1:0]          dly = 2'h0;
  pteu_pkg::pteu_cmd_s cmd = '0;
  pteu_pkg::pteu_cmd_s cur;
  pteu_pkg::pteu_op_s  op;
  pteu_pkg::pteu_opc_e c;
  pteu_pkg::pteu_opc_e eq[$];
  logic                rdy, done, refs, req, ack, req_q;
  logic [63:0]         rdata, loaded;
  logic [31:0]         rnd = 32'h04E5D435;
  int                  err_count = 0;
  int                  compares = 0;
  int                  i;
  logic                hung = 1'b0;
  always #2 clk = ~clk;
  pteu_sequencer pteu_sequencer_i (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(vld), .CMD_I(cmd),
    .MP_SYSTEM_I(mp), .CMD_READY_O(rdy), .CMD_DONE_O(done), .CMD_REF_WAS_SET_O(refs), .OP_REQ_O(req),
    .OP_O(op), .OP_ACK_I(ack), .OP_RDATA_I(rdata));
  pteu_dev_model pteu_dev_model_i (.clk_i(clk), .rst_i(rst), .req_i(req), .op_i(op), .ref_i(ref_b),
    .fail_i(fail), .dly_i(dly), .ack_o(ack), .rdata_o(rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] adr(input pteu_pkg::pteu_opc_e o);
    case (o)
      pteu_pkg::OPC_INVALIDATE: return cur.old_vpn;
      pteu_pkg::OPC_READ_RBYTE, pteu_pkg::OPC_STORE_RBYTE: return cur.addr + pteu_pkg::RBYTE_OFFSET;
      pteu_pkg::OPC_STORE_LOW, pteu_pkg::OPC_RESV_LOAD,
        pteu_pkg::OPC_COND_STORE: return cur.addr + pteu_pkg::LOW_DW_OFFSET;
      pteu_pkg::OPC_LOCK, pteu_pkg::OPC_UNLOCK, pteu_pkg::OPC_STORE_HIGH,
        pteu_pkg::OPC_CLEAR_VALID: return cur.addr;
      default: return 64'h0;
    endcase
  endfunction
  task automatic put(input pteu_pkg::pteu_opc_e o, input logic mo);
    if (mp || !mo) eq.push_back(o);
  endtask
  // ---------------------------------------------------------------------------
  // reference sequences, built when a command is taken
  // ---------------------------------------------------------------------------
  task automatic build();
    put(pteu_pkg::OPC_LOCK, 1'b1);
    case (cur.kind)
      pteu_pkg::CMD_ADD: ;
      pteu_pkg::CMD_CLEAR_REF: put(pteu_pkg::OPC_READ_RBYTE, 1'b0);
      pteu_pkg::CMD_MODIFY_VA: put(pteu_pkg::OPC_STORE_HIGH, 1'b0);
      pteu_pkg::CMD_MODIFY_PROT: begin
        put(pteu_pkg::OPC_ENTRY_SYNC, 1'b0);
        repeat (fail ? 2 : 1) begin
          put(pteu_pkg::OPC_RESV_LOAD, 1'b0);
          put(pteu_pkg::OPC_COND_STORE, 1'b0);
        end
      end
      default: put(pteu_pkg::OPC_CLEAR_VALID, 1'b0);
    endcase
    if (cur.kind == pteu_pkg::CMD_CLEAR_REF && ref_b) put(pteu_pkg::OPC_STORE_RBYTE, 1'b0);
    else if (cur.kind != pteu_pkg::CMD_CLEAR_REF && cur.kind != pteu_pkg::CMD_ADD) put(pteu_pkg::OPC_ENTRY_SYNC, 1'b0);
    if (cur.kind != pteu_pkg::CMD_ADD && (cur.kind != pteu_pkg::CMD_CLEAR_REF || ref_b)) begin
      put(pteu_pkg::OPC_INVALIDATE, 1'b0);
      put(pteu_pkg::OPC_BARRIER, 1'b1);
      put(pteu_pkg::OPC_INV_SYNC, 1'b1);
      put(pteu_pkg::OPC_ENTRY_SYNC, 1'b0);
    end
    if (cur.kind == pteu_pkg::CMD_ADD || cur.kind == pteu_pkg::CMD_MODIFY) begin
      put(pteu_pkg::OPC_STORE_LOW, 1'b0);
      put(pteu_pkg::OPC_BARRIER, 1'b0);
      put(pteu_pkg::OPC_STORE_HIGH, 1'b0);
      put(pteu_pkg::OPC_ENTRY_SYNC, 1'b0);
    end
    put(pteu_pkg::OPC_UNLOCK, 1'b1);
  endtask
  always @(posedge clk) begin
    req_q <= req;
    if (req && ack) loaded = rdata;
    if (req && !req_q) begin
      `CHK("more", 1'b1, eq.size() > 0)
      c = (eq.size() > 0) ? eq.pop_front() : pteu_pkg::OPC_LOCK;
      `CHK("code", c, op.code)
      `CHK("addr", adr(c), op.addr)
      if (c == pteu_pkg::OPC_STORE_HIGH) `CHK("high", cur.high | 64'h1, op.data)
      if (c == pteu_pkg::OPC_STORE_RBYTE) `CHK("rbyte", loaded[7:0] & 8'hFE, op.data[7:0])
      if (c == pteu_pkg::OPC_COND_STORE)
        `CHK("cas", (loaded & ~pteu_pkg::PROT_MASK) | (cur.low & pteu_pkg::PROT_MASK), op.data)
    end
  end
  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // back to back: next command offered right after the done edge
  task automatic run(input pteu_pkg::pteu_cmd_e k, input logic m);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      cmd[i*32 +: 32] = rnd;
    end
    cmd.kind = k;
    cmd.addr[3:0] = 4'h0;
    {fail, ref_b, dly} = rnd[3:0];
    mp = m;
    vld = 1'b1;
    @(posedge clk);
    cur = cmd;
    eq.delete();
    build();
    #1;
    vld = 1'b0;
    `CHK("busy", 1'b0, rdy)
    cmd = ~cmd;
    mp = ~mp;
    for (i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("done", 1'b1, done)
    hung = (done !== 1'b1);
    if (!hung) begin
      `CHK("ready", 1'b1, rdy)
      `CHK("left", 0, eq.size())
      `CHK("ref", cur.kind == pteu_pkg::CMD_CLEAR_REF && ref_b, refs)
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("idle", 1'b1, rdy && !req && !done)
    for (int r = 0; r < 4; r++) for (int k = 0; k < 6; k++) if (!hung) run(pteu_pkg::pteu_cmd_e'(k), r[0]);
    test_done();
  end
endmodule
`default_nettype wire
